/* design/bmr_consts.svh */
// Purpose: Constants for the burst memory response logic
// Assumes: Included by bare name from package and modules
// Notes: Channel indices, one-hot state codes and widths
`ifndef BMR_CONSTS_SVH
`define BMR_CONSTS_SVH

// ----------------------------------------------------------------
// Channel indices
// ----------------------------------------------------------------
`define BMR_CH_I 0
`define BMR_CH_D 1
`define BMR_NCH 2

// ----------------------------------------------------------------
// Bus widths and defaults
// ----------------------------------------------------------------
`define BMR_AW_BUS 32
`define BMR_DW 32
`define BMR_WORD_LSB 2
`define BMR_MEM_AW 8
`define BMR_LEN_W 4
`define BMR_BASE 32'h0000_0000
`define BMR_ZERO32 32'h0000_0000

// ----------------------------------------------------------------
// Memory end state codes
// ----------------------------------------------------------------
`define BMR_M_IDLE 4'h1
`define BMR_M_BURST 4'h2
`define BMR_M_LAST 4'h4
`define BMR_M_SGL 4'h8

// ----------------------------------------------------------------
// Processor end state codes
// ----------------------------------------------------------------
`define BMR_P_IDLE 4'h1
`define BMR_P_REQ 4'h2
`define BMR_P_BURST 4'h4
`define BMR_P_LAST 4'h8

`endif

/* design/bmr_pkg.sv */
// Purpose: Types for the burst memory response logic
// Assumes: bmr_consts.svh provides the codes
// Notes: One-hot state enums for both ends
`include "bmr_consts.svh"

package bmr_pkg;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        M_IDLE = `BMR_M_IDLE,
        M_BURST = `BMR_M_BURST,
        M_LAST = `BMR_M_LAST,
        M_SGL = `BMR_M_SGL
    } bmr_mst_t;

    typedef enum logic [3:0] {
        P_IDLE = `BMR_P_IDLE,
        P_REQ = `BMR_P_REQ,
        P_BURST = `BMR_P_BURST,
        P_LAST = `BMR_P_LAST
    } bmr_pst_t;

    typedef logic [`BMR_DW-1:0] bmr_word_t;

endpackage

/* design/bmr_if.sv */
// Purpose: Channel between processor end and memory end
// Assumes: Single clock, all lines driven every cycle
// Notes: Response lines come from the one memory end; only pipeline enable is an OR merge
`timescale 1ns/100ps
`include "bmr_consts.svh"

interface bmr_if;
    // Processor requests
    logic instr_request;
    logic instr_burst_request;
    logic data_request;
    logic data_burst_request;
    logic [`BMR_AW_BUS-1:0] addr;
    logic data_write;
    logic [`BMR_DW-1:0] data_wdata;
    // Memory responses
    logic instr_ready_resp;
    logic data_ready_resp;
    logic instr_error_resp;
    logic data_error_resp;
    logic instr_burst_ack;
    logic data_burst_ack;
    logic pipeline_enable_resp;
    logic [`BMR_DW-1:0] instr_rdata;
    logic [`BMR_DW-1:0] data_rdata;

    modport mem (
        input instr_request, instr_burst_request, data_request,
        input data_burst_request, addr, data_write, data_wdata,
        output instr_ready_resp, data_ready_resp, instr_error_resp,
        output data_error_resp, instr_burst_ack, data_burst_ack,
        output pipeline_enable_resp, instr_rdata, data_rdata
    );

    modport proc (
        output instr_request, instr_burst_request, data_request,
        output data_burst_request, addr, data_write, data_wdata,
        input instr_ready_resp, data_ready_resp, instr_error_resp,
        input data_error_resp, instr_burst_ack, data_burst_ack,
        input pipeline_enable_resp, instr_rdata, data_rdata
    );
endinterface

/* design/bmr_mem_end.sv */
// Purpose: Memory side burst response logic, instr and data channel
// Assumes: Requests sampled synchronously to core_clk_i
// Notes: Channel 0 is instruction, channel 1 is data
//
// Function
// - Only selected memory drives shared pipeline enable
// - Strap pipeline enable only if bus uniform
// - Processor starts burst with burst request, request
// - Address valid whenever a request is active
// - Memory establishes burst by asserting burst ack
// - Processor drops request after burst ack
// - Capture request and address at ack cycle
// - Hold burst ack while awaiting resumption
// - New burst under held ack: latch, restart
// - No ready stall; restart takes one cycle
// - Optional combinational ack gated by request
// - Capture new address as early as possible
// - Preempt burst by negating burst ack
// - One last word after preempt, then new access
// - No ready on first burst request reassertion
// - Responses valid every cycle, one driver
// - Merge interface responses with logical OR; only pipeline enable is OR-merged here
// - Write enable pulse in latter half cycle
`timescale 1ns/100ps
`include "bmr_consts.svh"

module bmr_mem_end
    import bmr_pkg::*;
#(
    parameter logic [`BMR_AW_BUS-1:0] BASE = `BMR_BASE,
    parameter int AW = `BMR_MEM_AW,
    parameter bit PEN_SUPPORT = 1'b1
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Processor channel
    bmr_if.mem bus,
    // User side control
    input wire logic [`BMR_NCH-1:0] preempt_i,
    // User side status
    output logic [`BMR_NCH-1:0] busy_o,
    output logic mem_we_n_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic addr_hit(input logic [`BMR_AW_BUS-1:0] a);
        logic [`BMR_AW_BUS-1:0] off;
        off = a - BASE;
        addr_hit = (off >> (AW + `BMR_WORD_LSB)) == `BMR_ZERO32;
    endfunction

    function automatic logic [AW-1:0] addr_idx(
        input logic [`BMR_AW_BUS-1:0] a);
        logic [`BMR_AW_BUS-1:0] off;
        off = a - BASE;
        addr_idx = off[AW+`BMR_WORD_LSB-1:`BMR_WORD_LSB];
    endfunction

    function automatic logic or_resp(input logic [`BMR_NCH-1:0] t);
        or_resp = |t;
    endfunction

    // ------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------
    localparam int DEPTH = 1 << AW;
    localparam logic [AW-1:0] TOP = {AW{1'b1}};

    bmr_word_t mem_q [DEPTH];
    bmr_mst_t st_q [`BMR_NCH];
    bmr_mst_t st_d [`BMR_NCH];
    logic [AW-1:0] ptr_q [`BMR_NCH];
    logic [AW-1:0] ptr_d [`BMR_NCH];
    bmr_word_t rdata_q [`BMR_NCH];
    logic [`BMR_NCH-1:0] breq_prev_q;

    logic [`BMR_NCH-1:0] req;
    logic [`BMR_NCH-1:0] breq;
    logic [`BMR_NCH-1:0] ack;
    logic [`BMR_NCH-1:0] rdy;
    logic [`BMR_NCH-1:0] err;
    logic [`BMR_NCH-1:0] pen_t;
    logic hit;
    logic [AW-1:0] idx;
    logic wr_now;

    assign req[`BMR_CH_I] = bus.instr_request;
    assign req[`BMR_CH_D] = bus.data_request;
    assign breq[`BMR_CH_I] = bus.instr_burst_request;
    assign breq[`BMR_CH_D] = bus.data_burst_request;
    // Address only meaningful while a request is up
    assign hit = addr_hit(bus.addr);
    assign idx = addr_idx(bus.addr);

    // ------------------------------------------------------------
    // Channel control
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < `BMR_NCH; c++) begin
            st_d[c] = st_q[c];
            ptr_d[c] = ptr_q[c];
            ack[c] = 1'b0;
            rdy[c] = 1'b0;
            err[c] = 1'b0;
            pen_t[c] = 1'b0;
            case (st_q[c])
                M_IDLE: begin
                    if (req[c] && hit) begin
                        // Capture address in the request cycle
                        ptr_d[c] = idx;
                        pen_t[c] = PEN_SUPPORT;
                        if (breq[c]) begin
                            ack[c] = 1'b1;
                            st_d[c] = M_BURST;
                        end else begin
                            st_d[c] = M_SGL;
                        end
                    end
                end
                M_BURST: begin
                    if (preempt_i[c]) begin
                        // Ack drops; owe a word if burst was asked
                        st_d[c] = breq_prev_q[c] ? M_LAST : M_IDLE;
                    end else if (req[c] && hit) begin
                        // Restart under held ack, no ready stall
                        ptr_d[c] = idx;
                        pen_t[c] = PEN_SUPPORT;
                        if (breq[c]) begin
                            ack[c] = 1'b1;
                        end else begin
                            st_d[c] = M_SGL;
                        end
                    end else if (req[c]) begin
                        // Access belongs to another interface
                        st_d[c] = M_IDLE;
                    end else begin
                        // Ack held while suspended or done
                        ack[c] = 1'b1;
                        if (breq[c] && breq_prev_q[c]) begin
                            // First reassertion gets no ready
                            if (ptr_q[c] == TOP) begin
                                err[c] = 1'b1;
                                st_d[c] = M_IDLE;
                            end else begin
                                rdy[c] = 1'b1;
                                ptr_d[c] = ptr_q[c] + 1'b1;
                            end
                        end
                    end
                end
                M_LAST: begin
                    // Last word owed after preemption
                    rdy[c] = 1'b1;
                    st_d[c] = M_IDLE;
                end
                M_SGL: begin
                    rdy[c] = 1'b1;
                    st_d[c] = M_IDLE;
                end
                default: begin
                    st_d[c] = M_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int c = 0; c < `BMR_NCH; c++) begin
                st_q[c] <= M_IDLE;
                ptr_q[c] <= '0;
            end
        end else begin
            for (int c = 0; c < `BMR_NCH; c++) begin
                st_q[c] <= st_d[c];
                ptr_q[c] <= ptr_d[c];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            breq_prev_q <= '0;
        end else begin
            breq_prev_q <= breq;
        end
    end

    // ------------------------------------------------------------
    // Storage array and read data
    // ------------------------------------------------------------
    assign wr_now = rdy[`BMR_CH_D] && bus.data_write;

    always_ff @(posedge core_clk_i) begin
        if (wr_now) begin
            mem_q[ptr_q[`BMR_CH_D]] <= bus.data_wdata;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int c = 0; c < `BMR_NCH; c++) begin
                rdata_q[c] <= '0;
            end
        end else begin
            for (int c = 0; c < `BMR_NCH; c++) begin
                rdata_q[c] <= mem_q[ptr_d[c]];
            end
        end
    end

    // ------------------------------------------------------------
    // Write strobe
    // ------------------------------------------------------------
    // Low half of the cycle only, ends at the rising edge
    assign mem_we_n_o = ~(wr_now & ~core_clk_i);

    // ------------------------------------------------------------
    // Response lines
    // ------------------------------------------------------------
    // Driven every cycle from this interface alone
    assign bus.instr_burst_ack = ack[`BMR_CH_I];
    assign bus.data_burst_ack = ack[`BMR_CH_D];
    assign bus.instr_ready_resp = rdy[`BMR_CH_I];
    assign bus.data_ready_resp = rdy[`BMR_CH_D];
    assign bus.instr_error_resp = err[`BMR_CH_I];
    assign bus.data_error_resp = err[`BMR_CH_D];
    // Per-channel terms merged by OR, no three-state
    assign bus.pipeline_enable_resp = or_resp(pen_t);
    assign bus.instr_rdata = rdata_q[`BMR_CH_I];
    assign bus.data_rdata = rdata_q[`BMR_CH_D];

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < `BMR_NCH; c++) begin
            busy_o[c] = st_q[c] != M_IDLE;
        end
    end

endmodule

/* design/bmr_proc_end.sv */
// Purpose: Processor side request logic for instr and data channel
// Assumes: Memory responses valid at the end of every cycle
// Notes: Channel 0 is instruction, channel 1 is data
`timescale 1ns/100ps
`include "bmr_consts.svh"

module bmr_proc_end
    import bmr_pkg::*;
#(
    parameter int LW = `BMR_LEN_W
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Memory channel
    bmr_if.proc bus,
    // User side commands
    input wire logic [`BMR_NCH-1:0] start_i,
    input wire logic [`BMR_NCH-1:0] burst_i,
    input wire logic [`BMR_NCH-1:0] suspend_i,
    input wire logic [`BMR_NCH-1:0][`BMR_AW_BUS-1:0] addr_i,
    input wire logic [`BMR_NCH-1:0][LW-1:0] len_i,
    input wire logic data_wr_i,
    input wire logic [`BMR_DW-1:0] wdata_i,
    // User side results
    output logic [`BMR_NCH-1:0] word_valid_o,
    output logic [`BMR_NCH-1:0][`BMR_DW-1:0] word_o,
    output logic [`BMR_NCH-1:0] done_o,
    output logic [`BMR_NCH-1:0] error_o,
    output logic [`BMR_NCH-1:0] busy_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bmr_pst_t st_q [`BMR_NCH];
    bmr_pst_t st_d [`BMR_NCH];
    logic [`BMR_AW_BUS-1:0] addr_q [`BMR_NCH];
    logic [LW-1:0] left_q [`BMR_NCH];
    logic [`BMR_NCH-1:0] bst_q;
    logic [`BMR_NCH-1:0] breq_prev_q;
    logic wr_q;
    logic [`BMR_DW-1:0] wdata_q;

    logic [`BMR_NCH-1:0] req;
    logic [`BMR_NCH-1:0] breq;
    logic [`BMR_NCH-1:0] grant;
    logic [`BMR_NCH-1:0] ack;
    logic [`BMR_NCH-1:0] rdy;
    logic [`BMR_NCH-1:0] err;
    logic [`BMR_NCH-1:0] fin;
    bmr_word_t rdata [`BMR_NCH];

    assign ack = {bus.data_burst_ack, bus.instr_burst_ack};
    assign rdy = {bus.data_ready_resp, bus.instr_ready_resp};
    assign err = {bus.data_error_resp, bus.instr_error_resp};
    assign rdata[`BMR_CH_I] = bus.instr_rdata;
    assign rdata[`BMR_CH_D] = bus.data_rdata;

    // Shared address bus: instruction request first
    assign grant[`BMR_CH_I] = 1'b1;
    assign grant[`BMR_CH_D] = st_q[`BMR_CH_I] != P_REQ;

    // ------------------------------------------------------------
    // Request lines and transitions
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < `BMR_NCH; c++) begin
            st_d[c] = st_q[c];
            fin[c] = 1'b0;
            req[c] = (st_q[c] == P_REQ) && grant[c];
            breq[c] = ((st_q[c] == P_REQ) && bst_q[c]) ||
                ((st_q[c] == P_BURST) && (left_q[c] != '0) &&
                !suspend_i[c]);
            case (st_q[c])
                P_IDLE: begin
                    if (start_i[c]) begin
                        st_d[c] = P_REQ;
                    end
                end
                P_REQ: begin
                    if (!grant[c]) begin
                        st_d[c] = P_REQ;
                    end else if (err[c]) begin
                        st_d[c] = P_IDLE;
                    end else if (ack[c] && bst_q[c]) begin
                        // Request dropped next cycle
                        st_d[c] = P_BURST;
                    end else if (rdy[c]) begin
                        st_d[c] = P_IDLE;
                        fin[c] = 1'b1;
                    end
                end
                P_BURST: begin
                    if (err[c]) begin
                        st_d[c] = P_IDLE;
                    end else if (!ack[c] && !rdy[c]) begin
                        // Preempted; one word owed if asked
                        st_d[c] = breq_prev_q[c] ? P_LAST : P_IDLE;
                        fin[c] = !breq_prev_q[c];
                    end else if (rdy[c] && left_q[c] == LW'(1)) begin
                        st_d[c] = P_IDLE;
                        fin[c] = 1'b1;
                    end
                end
                P_LAST: begin
                    if (rdy[c]) begin
                        st_d[c] = P_IDLE;
                        fin[c] = 1'b1;
                    end
                end
                default: begin
                    st_d[c] = P_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int c = 0; c < `BMR_NCH; c++) begin
                st_q[c] <= P_IDLE;
                addr_q[c] <= '0;
                left_q[c] <= '0;
            end
            bst_q <= '0;
        end else begin
            for (int c = 0; c < `BMR_NCH; c++) begin
                st_q[c] <= st_d[c];
                if (st_q[c] == P_IDLE && start_i[c]) begin
                    addr_q[c] <= addr_i[c];
                    left_q[c] <= len_i[c];
                    bst_q[c] <= burst_i[c];
                end else if (rdy[c] && left_q[c] != '0) begin
                    left_q[c] <= left_q[c] - LW'(1);
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            breq_prev_q <= '0;
        end else begin
            breq_prev_q <= breq;
        end
    end

    // ------------------------------------------------------------
    // Write data
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_q <= 1'b0;
            wdata_q <= '0;
        end else begin
            if (st_q[`BMR_CH_D] == P_IDLE && start_i[`BMR_CH_D]) begin
                wr_q <= data_wr_i;
                wdata_q <= wdata_i;
            end else if (rdy[`BMR_CH_D]) begin
                wdata_q <= wdata_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus drive
    // ------------------------------------------------------------
    // Address held valid while request is up
    assign bus.addr = req[`BMR_CH_I] ? addr_q[`BMR_CH_I] :
        addr_q[`BMR_CH_D];
    assign bus.instr_request = req[`BMR_CH_I];
    assign bus.data_request = req[`BMR_CH_D];
    assign bus.instr_burst_request = breq[`BMR_CH_I];
    assign bus.data_burst_request = breq[`BMR_CH_D];
    assign bus.data_write = wr_q && (st_q[`BMR_CH_D] != P_IDLE);
    assign bus.data_wdata = wdata_q;

    // ------------------------------------------------------------
    // Results
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            word_valid_o <= '0;
            done_o <= '0;
            error_o <= '0;
            for (int c = 0; c < `BMR_NCH; c++) begin
                word_o[c] <= '0;
            end
        end else begin
            word_valid_o <= rdy & ~err;
            done_o <= fin;
            error_o <= err;
            for (int c = 0; c < `BMR_NCH; c++) begin
                if (rdy[c]) begin
                    word_o[c] <= rdata[c];
                end
            end
        end
    end

    always_comb begin
        for (int c = 0; c < `BMR_NCH; c++) begin
            busy_o[c] = st_q[c] != P_IDLE;
        end
    end

endmodule

/* test/bmr_checker.sv */
// Purpose: Protocol checks on the processor to memory channel
// Assumes: One clock, reset active low
// Notes: Sees only the channel lines
`timescale 1ns/100ps

module bmr_checker (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Requests
    input wire logic instr_request,
    input wire logic instr_burst_request,
    input wire logic data_request,
    input wire logic data_burst_request,
    // Responses
    input wire logic instr_ready_resp,
    input wire logic instr_error_resp,
    input wire logic data_ready_resp,
    input wire logic instr_burst_ack,
    input wire logic data_burst_ack,
    input wire logic pipeline_enable_resp
);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_burst_open;
        instr_request && instr_burst_request && !$past(instr_burst_request);
    endsequence

    sequence s_word_due;
        instr_burst_request && $past(instr_burst_request) &&
            instr_burst_ack && !instr_request;
    endsequence

    // Ack drop after an error response ends the burst, no word owed
    sequence s_pre_drop;
        $fell(instr_burst_ack) && $past(instr_burst_request) &&
            !$past(instr_error_resp) && !instr_request;
    endsequence

    ack_on_open_a: assert property (s_burst_open |-> instr_burst_ack)
        else $error("burst not acknowledged");
    pen_on_open_a: assert property (s_burst_open |-> pipeline_enable_resp)
        else $error("pipeline enable missing");
    pen_owner_a: assert property (
        pipeline_enable_resp |-> instr_request || data_request)
        else $error("pipeline enable without request");
    req_drop_a: assert property (
        instr_request && instr_burst_ack |=> !instr_request)
        else $error("instr request held after ack");
    data_request_drop_a: assert property (
        data_request && data_burst_ack |=> !data_request)
        else $error("data request held after ack");
    word_due_a: assert property (
        s_word_due |-> instr_ready_resp || instr_error_resp)
        else $error("burst word withheld");
    resume_quiet_a: assert property (
        $rose(instr_burst_request) |-> !instr_ready_resp)
        else $error("ready on burst request reassertion");
    last_word_a: assert property (
        s_pre_drop |=> instr_ready_resp || instr_error_resp)
        else $error("no last word after preemption");
    single_ans_a: assert property (
        $rose(data_request) && !data_burst_request |=> data_ready_resp)
        else $error("single access not answered");
endmodule

/* test/tb_burst_memory_response_logic.sv */
// Purpose: Self-checking bench for both channel ends
// Assumes: 100 MHz clock, reset low for 16 cycles
// Notes: Words written singly, then read back in bursts
`timescale 1ns/100ps

module tb_burst_memory_response_logic import bmr_pkg::*;;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [1:0] start_i = 2'h0;
    logic [1:0] burst_i = 2'h0;
    logic [1:0] suspend_i = 2'h0;
    logic [1:0] preempt_i = 2'h0;
    logic [1:0][31:0] addr_i = '0;
    logic [1:0][3:0] len_i = '0;
    logic data_wr_i = 1'b0;
    bmr_word_t wdata_i = 32'h0000_0000;
    bmr_word_t rnd = 32'h0000_0028;
    bmr_word_t e;
    logic [1:0] wv, done, err, pbusy, mbusy;
    logic [1:0] watch = 2'h3;
    logic [1:0][31:0] word;
    logic we_n;
    bmr_word_t exp_q[2][$];
    bmr_word_t mem_m[256];
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    int we_cnt = 0;

    always #5 core_clk_i = ~core_clk_i;

    bmr_if i_bmr_if();
    bmr_mem_end i_bmr_mem_end (.core_clk_i, .resetn_i, .bus(i_bmr_if),
        .preempt_i, .busy_o(mbusy), .mem_we_n_o(we_n));
    bmr_proc_end i_bmr_proc_end (.core_clk_i, .resetn_i, .bus(i_bmr_if),
        .start_i, .burst_i, .suspend_i, .addr_i, .len_i, .data_wr_i,
        .wdata_i, .word_valid_o(wv), .word_o(word), .done_o(done),
        .error_o(err), .busy_o(pbusy));
    bmr_checker i_bmr_checker (.core_clk_i, .resetn_i,
        .instr_request(i_bmr_if.instr_request),
        .instr_burst_request(i_bmr_if.instr_burst_request),
        .data_request(i_bmr_if.data_request),
        .data_burst_request(i_bmr_if.data_burst_request),
        .instr_ready_resp(i_bmr_if.instr_ready_resp),
        .instr_error_resp(i_bmr_if.instr_error_resp),
        .data_ready_resp(i_bmr_if.data_ready_resp),
        .instr_burst_ack(i_bmr_if.instr_burst_ack),
        .data_burst_ack(i_bmr_if.data_burst_ack),
        .pipeline_enable_resp(i_bmr_if.pipeline_enable_resp));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic bmr_word_t lfsr(bmr_word_t s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(string what, bmr_word_t x, bmr_word_t g);
        tests_run++;
        if (g !== x) begin
            err_total++;
            $display("Error %s: expected %h seen %h", what, x, g);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Modes: 0 plain, 1 suspend, 2 preempt, 3 write, 4 past top
    task automatic run(int c, bit b, int idx, int n, int m);
        @(posedge core_clk_i);
        start_i[c] <= 1'b1;
        burst_i[c] <= b;
        addr_i[c] <= idx << 2;
        len_i[c] <= n[3:0];
        watch[c] <= (m != 3);
        if (c == 1)
            data_wr_i <= (m == 3);
        for (int k = 0; k < n && m != 3; k++)
            exp_q[c].push_back(mem_m[(idx + k) % 256]);
        if (m == 3) begin
            rnd = lfsr(rnd);
            wdata_i <= rnd;
            mem_m[idx] = rnd;
        end
        @(posedge core_clk_i);
        start_i[c] <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        suspend_i[c] <= (m == 1);
        preempt_i[c] <= (m == 2);
        repeat (m == 1 ? 4 : 1) @(posedge core_clk_i);
        suspend_i[c] <= 1'b0;
        preempt_i[c] <= 1'b0;
        repeat (80) begin
            if (done[c] | err[c])
                break;
            @(posedge core_clk_i);
        end
        chk("end", 1, done[c] | err[c]);
        @(negedge core_clk_i);
        if (m < 2)
            chk("left", 0, exp_q[c].size());
        chk("pbusy", 0, pbusy[c]);
        chk("mbusy", b && m < 2, mbusy[c]);
        exp_q[c].delete();
        $display("Test ch%0d word %0d mode %0d done", c, idx, m);
    endtask

    // Oldest note against each returned word, plus hang limit
    always @(posedge core_clk_i) begin
        cyc++;
        for (int c = 0; c < 2; c++) begin
            if (wv[c] === 1'b1 && watch[c] === 1'b1) begin
                e = exp_q[c].size() ? exp_q[c].pop_front() : 'x;
                chk("word", e, word[c]);
            end
        end
        if (cyc == 6000) begin
            err_total++;
            end_sim();
        end
    end

    always @(negedge core_clk_i) #2 we_cnt += (we_n === 1'b0);
    always @(posedge core_clk_i) #2 if (resetn_i && we_n !== 1'b1)
        chk("we_n", 1, we_n);

    initial begin
        repeat (16) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        for (int i = 240; i < 256; i++)
            run(1, 0, i, 1, 3);
        chk("we pulses", 16, we_cnt);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            fork
                run(0, 1, 240 + rnd[2:0], rnd[5:3] + 1, 0);
                run(1, 1, 240 + rnd[8:6], rnd[11:9] + 1, 0);
            join
        end
        run(0, 0, 245, 1, 0);
        run(0, 1, 240, 8, 1);
        run(0, 1, 240, 8, 2);
        run(0, 1, 244, 4, 0);
        run(0, 1, 254, 4, 4);
        @(posedge core_clk_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        run(0, 1, 248, 2, 0);
        end_sim();
    end
endmodule
